// ==== verilog/sbc_pkg.sv ====
package sbc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam real CLK_PERIOD_NS   = 5.0;
    localparam real OFF_MIN_US      = 18.96;
    localparam real OFF_MAX_US      = 28.95;
    localparam int  OFF_MIN_CYC     = int'($ceil(OFF_MIN_US * 1000.0 / CLK_PERIOD_NS));
    localparam int  OFF_MAX_CYC_DEF = int'($floor(OFF_MAX_US * 1000.0 / CLK_PERIOD_NS));
    localparam int  SETTLE_BASE_DEF = 256;
    localparam int  CNT_W           = 24;

    localparam logic [CNT_W-1:0] WAIT_XTAL_VEC  = 24'h00000A;
    localparam logic [CNT_W-1:0] WAIT_XTAL_NVEC = 24'h000004;
    localparam logic [CNT_W-1:0] WAIT_INT_VEC   = 24'h000007;
    localparam logic [CNT_W-1:0] WAIT_INT_NVEC  = 24'h000001;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;

    localparam int CTRL_WD_STBY   = 0;
    localparam int CTRL_WD_EN     = 1;
    localparam int CTRL_XTAL      = 2;
    localparam int CTRL_SEL_LO    = 4;
    localparam int SEL_W          = 3;

    localparam int STAT_SLEEP     = 0;
    localparam int STAT_INTERMEDIATE_WAKEUP_STATE    = 1;
    localparam int STAT_SETTLED   = 2;
    localparam int STAT_ELAPSE_LO = 8;

    localparam logic [31:0] CTRL_RESET = 32'h00000000;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_STOP,
        ST_INTERMEDIATE_WAKEUP_STATE,
        ST_SETTLE,
        ST_WAIT
    } sbc_state_t;

endpackage

// ==== verilog/sbc_if.sv ====
`timescale 1ns/1ps
interface sbc_if (
    input wire logic hclk,
    input wire logic hresetn
);
    logic stop_req;
    logic wake_req;
    logic ack_en;
    logic cpu_clk_on;
    logic take_vector;
    logic resume_next;

    modport dev_mp (
        input  stop_req,
        input  wake_req,
        input  ack_en,
        output cpu_clk_on,
        output take_vector,
        output resume_next
    );

    modport host_mp (
        output stop_req,
        output wake_req,
        output ack_en,
        input  cpu_clk_on,
        input  take_vector,
        input  resume_next
    );
endinterface

// ==== verilog/stop_mode_standby_control.sv ====
`timescale 1ns/1ps
module stop_mode_standby_control #(
    parameter int OFF_MAX_CYC = sbc_pkg::OFF_MAX_CYC_DEF,
    parameter int SETTLE_BASE = sbc_pkg::SETTLE_BASE_DEF
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    sbc_if.dev_mp            cpu,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        adc_trigger,
    input  wire logic        serial0_rx_trigger,
    input  wire logic        intermediate_wakeup_state_done,
    output logic             wdt_run,
    output logic             slow_osc_run,
    output logic             adc_wake_en,
    output logic             serial0_wake_en,
    output logic             serial_other_en,
    output logic             two_wire_match_en,
    output logic             auto_halt,
    output logic             always_on_en,
    output logic             intermediate_wakeup_state_active
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [sbc_pkg::CNT_W-1:0] settle_cycles(
        input logic [sbc_pkg::SEL_W-1:0] sel
    );
        settle_cycles = sbc_pkg::CNT_W'(SETTLE_BASE) << sel;
    endfunction

    function automatic logic [sbc_pkg::CNT_W-1:0] off_cycles(
        input logic [sbc_pkg::SEL_W-1:0] sel
    );
        logic [sbc_pkg::CNT_W-1:0] s;
        s = settle_cycles(sel);
        off_cycles = (s < sbc_pkg::CNT_W'(sbc_pkg::OFF_MIN_CYC))
                     ? sbc_pkg::CNT_W'(sbc_pkg::OFF_MIN_CYC) : s;
    endfunction

    // ****************************************
    // Register bus
    // ****************************************
    logic [31:0]                ctrl_ff, nxt_ctrl;
    logic                       wr_pend_ff, nxt_wr_pend;
    logic [7:0]                 wr_addr_ff, nxt_wr_addr;
    logic [31:0]                hrdata_ff, nxt_hrdata;
    logic [sbc_pkg::CNT_W-1:0]  elapse_ff, nxt_elapse;
    logic                       settled_ff, nxt_settled;
    sbc_pkg::sbc_state_t        state_ff, nxt_state;

    logic                        stby;
    logic                        xtal;
    logic [sbc_pkg::SEL_W-1:0]   sel;
    logic                        addr_ok;

    assign stby    = ctrl_ff[sbc_pkg::CTRL_WD_STBY];
    assign xtal    = ctrl_ff[sbc_pkg::CTRL_XTAL];
    assign sel     = ctrl_ff[sbc_pkg::CTRL_SEL_LO +: sbc_pkg::SEL_W];
    assign addr_ok = hsel && hready && (htrans == sbc_pkg::HTRANS_NONSEQ);

    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_wr_pend = addr_ok && hwrite;
        nxt_wr_addr = addr_ok ? haddr[7:0] : wr_addr_ff;
        nxt_hrdata  = hrdata_ff;
        if (wr_pend_ff && (wr_addr_ff == sbc_pkg::OFS_CTRL)) begin
            nxt_ctrl = hwdata;
            if (stby && ctrl_ff[sbc_pkg::CTRL_WD_EN]) begin
                nxt_ctrl[sbc_pkg::CTRL_WD_EN] = 1'b1;
            end
        end
        if (addr_ok && !hwrite) begin
            nxt_hrdata = '0;
            if (haddr[7:0] == sbc_pkg::OFS_CTRL) begin
                nxt_hrdata = ctrl_ff;
            end else if (haddr[7:0] == sbc_pkg::OFS_STATUS) begin
                nxt_hrdata[sbc_pkg::STAT_SLEEP]   = (state_ff != sbc_pkg::ST_RUN);
                nxt_hrdata[sbc_pkg::STAT_INTERMEDIATE_WAKEUP_STATE]  = (state_ff == sbc_pkg::ST_INTERMEDIATE_WAKEUP_STATE);
                nxt_hrdata[sbc_pkg::STAT_SETTLED] = settled_ff;
                nxt_hrdata[sbc_pkg::STAT_ELAPSE_LO +: sbc_pkg::CNT_W] = elapse_ff;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff    <= sbc_pkg::CTRL_RESET;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            hrdata_ff  <= '0;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            hrdata_ff  <= nxt_hrdata;
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = sbc_pkg::HRESP_OKAY;

    // ****************************************
    // Sleep sequencer
    // ****************************************
    logic [sbc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic                      quick_ff, nxt_quick;
    logic                      clk_on_ff, nxt_clk_on;
    logic                      vec_ff, nxt_vec;
    logic                      res_ff, nxt_res;
    logic [sbc_pkg::CNT_W-1:0] wait_len;

    assign wait_len = xtal ? (cpu.ack_en ? sbc_pkg::WAIT_XTAL_VEC
                                         : sbc_pkg::WAIT_XTAL_NVEC)
                           : (cpu.ack_en ? sbc_pkg::WAIT_INT_VEC : sbc_pkg::WAIT_INT_NVEC);

    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_quick   = quick_ff;
        nxt_vec     = 1'b0;
        nxt_res     = 1'b0;
        nxt_elapse  = elapse_ff;
        nxt_settled = settled_ff;
        unique case (state_ff)
            sbc_pkg::ST_RUN: begin
                if (cpu.stop_req) begin
                    nxt_elapse  = '0;
                    nxt_settled = 1'b0;
                    if (cpu.wake_req) begin
                        nxt_state = sbc_pkg::ST_SETTLE;
                        nxt_cnt   = settle_cycles(sel);
                        nxt_quick = 1'b1;
                    end else begin
                        nxt_state = sbc_pkg::ST_STOP;
                        nxt_quick = 1'b0;
                    end
                end
            end
            sbc_pkg::ST_STOP, sbc_pkg::ST_INTERMEDIATE_WAKEUP_STATE: begin
                if (cpu.wake_req) begin
                    nxt_state = sbc_pkg::ST_SETTLE;
                    nxt_cnt   = xtal ? off_cycles(sel) : settle_cycles(sel);
                end else if (state_ff == sbc_pkg::ST_STOP) begin
                    if (adc_trigger || serial0_rx_trigger) begin
                        nxt_state = sbc_pkg::ST_INTERMEDIATE_WAKEUP_STATE;
                    end
                end else if (intermediate_wakeup_state_done) begin
                    nxt_state = sbc_pkg::ST_STOP;
                end
            end
            sbc_pkg::ST_SETTLE: begin
                if (elapse_ff != '1) begin
                    nxt_elapse = elapse_ff + 1'b1;
                end
                if (cnt_ff <= 1) begin
                    nxt_settled = 1'b1;
                    if (quick_ff) begin
                        nxt_state = sbc_pkg::ST_RUN;
                        nxt_vec   = cpu.ack_en;
                        nxt_res   = !cpu.ack_en;
                    end else begin
                        nxt_state = sbc_pkg::ST_WAIT;
                        nxt_cnt   = wait_len;
                    end
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            sbc_pkg::ST_WAIT: begin
                if (cnt_ff <= 1) begin
                    nxt_state = sbc_pkg::ST_RUN;
                    nxt_vec   = cpu.ack_en;
                    nxt_res   = !cpu.ack_en;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_state = sbc_pkg::ST_RUN;
            end
        endcase
        nxt_clk_on = (nxt_state == sbc_pkg::ST_RUN) || (nxt_state == sbc_pkg::ST_WAIT)
                     || (nxt_state == sbc_pkg::ST_SETTLE && nxt_quick);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff   <= sbc_pkg::ST_RUN;
            cnt_ff     <= '0;
            quick_ff   <= 1'b0;
            clk_on_ff  <= 1'b1;
            vec_ff     <= 1'b0;
            res_ff     <= 1'b0;
            elapse_ff  <= '0;
            settled_ff <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            quick_ff   <= nxt_quick;
            clk_on_ff  <= nxt_clk_on;
            vec_ff     <= nxt_vec;
            res_ff     <= nxt_res;
            elapse_ff  <= nxt_elapse;
            settled_ff <= nxt_settled;
        end
    end

    assign cpu.cpu_clk_on  = clk_on_ff;
    assign cpu.take_vector = vec_ff;
    assign cpu.resume_next = res_ff;

    // ****************************************
    // Peripheral gating
    // ****************************************
    logic gate_wdt_ff, nxt_gate_wdt;
    logic gate_lo_ff, nxt_gate_lo;
    logic gate_sleep_ff, nxt_gate_sleep;
    logic gate_snz_ff, nxt_gate_snz;

    always_comb begin
        nxt_gate_sleep = (nxt_state == sbc_pkg::ST_STOP) || (nxt_state == sbc_pkg::ST_INTERMEDIATE_WAKEUP_STATE);
        nxt_gate_snz   = (nxt_state == sbc_pkg::ST_INTERMEDIATE_WAKEUP_STATE);
        nxt_gate_wdt   = nxt_ctrl[sbc_pkg::CTRL_WD_EN] && (!nxt_gate_sleep || stby);
        nxt_gate_lo    = !nxt_gate_sleep || stby;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_wdt_ff   <= 1'b0;
            gate_lo_ff    <= 1'b1;
            gate_sleep_ff <= 1'b0;
            gate_snz_ff   <= 1'b0;
        end else begin
            gate_wdt_ff   <= nxt_gate_wdt;
            gate_lo_ff    <= nxt_gate_lo;
            gate_sleep_ff <= nxt_gate_sleep;
            gate_snz_ff   <= nxt_gate_snz;
        end
    end

    assign wdt_run           = gate_wdt_ff;
    assign slow_osc_run      = gate_lo_ff;
    assign adc_wake_en       = gate_sleep_ff;
    assign serial0_wake_en   = gate_sleep_ff;
    assign serial_other_en   = !gate_sleep_ff;
    assign two_wire_match_en = gate_sleep_ff;
    assign auto_halt         = gate_sleep_ff;
    assign always_on_en      = hresetn;
    assign intermediate_wakeup_state_active     = gate_snz_ff;

endmodule

// ==== verilog/sleep_cpu_side.sv ====
`timescale 1ns/1ps
module sleep_cpu_side (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    sbc_if.host_mp          dev,
    input  wire logic [7:0] irq_flag,
    input  wire logic [7:0] irq_mask,
    input  wire logic       int_ack_en,
    input  wire logic       sleep_exec,
    output logic            cpu_halted,
    output logic            vector_taken,
    output logic            resumed,
    output logic            reset_fetch
);

    // ****************************************
    // Request and status registers
    // ****************************************
    logic stop_ff, nxt_stop;
    logic wake_ff, nxt_wake;
    logic ack_ff, nxt_ack;
    logic halt_ff, nxt_halt;
    logic vec_ff, nxt_vec;
    logic res_ff, nxt_res;
    logic boot_ff, nxt_boot;
    logic fetch_ff, nxt_fetch;

    always_comb begin
        nxt_wake  = |(irq_flag & ~irq_mask);
        nxt_ack   = int_ack_en;
        nxt_stop  = sleep_exec && !halt_ff;
        nxt_halt  = halt_ff;
        if (sleep_exec && !halt_ff) begin
            nxt_halt = 1'b1;
        end else if (dev.take_vector || dev.resume_next) begin
            nxt_halt = 1'b0;
        end
        nxt_vec   = dev.take_vector;
        nxt_res   = dev.resume_next;
        nxt_boot  = 1'b1;
        nxt_fetch = !boot_ff;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stop_ff  <= 1'b0;
            wake_ff  <= 1'b0;
            ack_ff   <= 1'b0;
            halt_ff  <= 1'b0;
            vec_ff   <= 1'b0;
            res_ff   <= 1'b0;
            boot_ff  <= 1'b0;
            fetch_ff <= 1'b0;
        end else begin
            stop_ff  <= nxt_stop;
            wake_ff  <= nxt_wake;
            ack_ff   <= nxt_ack;
            halt_ff  <= nxt_halt;
            vec_ff   <= nxt_vec;
            res_ff   <= nxt_res;
            boot_ff  <= nxt_boot;
            fetch_ff <= nxt_fetch;
        end
    end

    assign dev.stop_req  = stop_ff;
    assign dev.wake_req  = wake_ff;
    assign dev.ack_en    = ack_ff;
    assign cpu_halted    = halt_ff;
    assign vector_taken  = vec_ff;
    assign resumed       = res_ff;
    assign reset_fetch   = fetch_ff;

endmodule

// ==== bench/stop_mode_standby_control_monitor.sv ====
`timescale 1ns/1ps
module stop_mode_standby_control_monitor #(
    parameter int OFF_MAX_CYC = sbc_pkg::OFF_MAX_CYC_DEF,
    parameter int SETTLE_BASE = sbc_pkg::SETTLE_BASE_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic stop_req,
    input wire logic wake_req,
    input wire logic ack_en,
    input wire logic cpu_clk_on,
    input wire logic take_vector,
    input wire logic resume_next
);
    localparam int SET_MAX = SETTLE_BASE << 7;
    localparam int OFF_LIM = (OFF_MAX_CYC > SET_MAX ? OFF_MAX_CYC : SET_MAX) + 2;
    logic        woke_ff;
    logic        nxt_woke;
    logic [23:0] off_ff;
    logic [23:0] nxt_off;
    logic [23:0] wk_ff;
    logic [23:0] nxt_wk;

    // ****************************************
    // Clock-off counters
    // ****************************************
    always_comb begin
        nxt_woke = (woke_ff || wake_req) && !cpu_clk_on;
        nxt_off  = cpu_clk_on ? 24'h000000 : off_ff + 24'h000001;
        nxt_wk   = (woke_ff && !cpu_clk_on) ? wk_ff + 24'h000001 : 24'h000000;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            woke_ff <= 1'b0;
            off_ff  <= 24'h000000;
            wk_ff   <= 24'h000000;
        end else begin
            woke_ff <= nxt_woke;
            off_ff  <= nxt_off;
            wk_ff   <= nxt_wk;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_stop_clk_off: assert property (stop_req && !wake_req && cpu_clk_on |=> !cpu_clk_on)
        else $error("clock kept running after sleep request");
    a_no_false_wake: assert property ($rose(cpu_clk_on) |-> woke_ff)
        else $error("clock restarted without wake request");
    a_off_min_time: assert property ($rose(cpu_clk_on) |-> off_ff >= SETTLE_BASE)
        else $error("clock off time too short");
    a_off_max_time: assert property (wk_ff <= OFF_LIM)
        else $error("clock off too long after wake");
    a_vector_wait: assert property ($rose(cpu_clk_on) && ack_en |->
        (!take_vector && !resume_next) [*6] ##[0:6] take_vector)
        else $error("vector pulse outside wait window");
    a_plain_wait: assert property ($rose(cpu_clk_on) && !ack_en |-> ##[1:6] resume_next)
        else $error("resume pulse outside wait window");
    a_ack_choice: assert property (take_vector || resume_next |-> take_vector == ack_en)
        else $error("wrong resume kind for acknowledge");
    a_pulse_once: assert property (take_vector || resume_next |=>
        !take_vector && !resume_next)
        else $error("wake pulse longer than one cycle");
    a_pending_clk: assert property (stop_req && wake_req |=> cpu_clk_on [*4])
        else $error("clock stopped with wake pending");
    a_pending_done: assert property (stop_req && wake_req |->
        ##[1:600] (take_vector || resume_next))
        else $error("pending wake not completed");

    c_vector: cover property ($rose(take_vector));
    c_resume: cover property ($rose(resume_next));
    c_pending: cover property (stop_req && wake_req);
    c_sleep: cover property ($fell(cpu_clk_on));
endmodule

// ==== bench/stop_mode_standby_control_tb.sv ====
`timescale 1ns/1ps
module stop_mode_standby_control_tb;
    localparam int SB = 4;
    logic        hclk;
    logic        hresetn;
    logic        hsel, hwrite, hreadyout, hresp, int_ack_en, sleep_exec;
    logic        adc_trigger, serial0_rx_trigger, intermediate_wakeup_state_done;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [7:0]  irq_flag, irq_mask;
    logic        wdt_run, slow_osc_run, adc_wake_en, serial0_wake_en, serial_other_en;
    logic        two_wire_match_en, auto_halt, always_on_en, intermediate_wakeup_state_active;
    logic        cpu_halted, vector_taken, resumed, reset_fetch;
    int          err_total, cmp_count, cyc, n, m, e, sel, xt, ack, stb, en, w;

    sbc_if i_sbc_if (.hclk, .hresetn);
    stop_mode_standby_control #(.SETTLE_BASE(SB)) i_stop_mode_standby_control (
        .hclk, .hresetn, .cpu(i_sbc_if), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .adc_trigger,
        .serial0_rx_trigger, .intermediate_wakeup_state_done, .wdt_run, .slow_osc_run, .adc_wake_en,
        .serial0_wake_en, .serial_other_en, .two_wire_match_en, .auto_halt,
        .always_on_en, .intermediate_wakeup_state_active);
    sleep_cpu_side i_sleep_cpu_side (.hclk, .hresetn, .dev(i_sbc_if), .irq_flag,
        .irq_mask, .int_ack_en, .sleep_exec, .cpu_halted, .vector_taken, .resumed,
        .reset_fetch);
    stop_mode_standby_control_monitor #(.SETTLE_BASE(SB)) i_mon (.hclk, .hresetn,
        .stop_req(i_sbc_if.stop_req), .wake_req(i_sbc_if.wake_req),
        .ack_en(i_sbc_if.ack_en), .cpu_clk_on(i_sbc_if.cpu_clk_on),
        .take_vector(i_sbc_if.take_vector), .resume_next(i_sbc_if.resume_next));

    always #2.5 hclk = ~hclk;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, x);
        end
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= sbc_pkg::HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk(hresp, sbc_pkg::HRESP_OKAY);
    endtask

    task automatic set_ctrl;
        en = (stb != 0 && en != 0) ? 1 : w[1];
        stb = w[0];
        bus(1'b1, sbc_pkg::OFS_CTRL, w);
        bus(1'b0, sbc_pkg::OFS_CTRL, 32'h0);
        chk(rd, {w[31:2], en[0], w[0]});
    endtask

    task automatic gates(input int s);
        chk(auto_halt, s);
        chk(adc_wake_en, s);
        chk(serial0_wake_en, s);
        chk(serial_other_en, !s);
        chk(two_wire_match_en, s);
        chk(always_on_en, 1);
        chk(wdt_run, en != 0 && (stb != 0 || s == 0));
        chk(slow_osc_run, stb != 0 || s == 0);
    endtask

    task automatic sleep_go;
        sleep_exec <= 1'b1;
        @(posedge hclk);
        sleep_exec <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    task automatic wake(input int b);
        irq_flag[b] <= 1'b1;
        irq_mask[b] <= 1'b0;
        n = 0;
        m = 0;
        while (i_sbc_if.wake_req !== 1'b1) @(posedge hclk);
        while (i_sbc_if.cpu_clk_on !== 1'b1) begin
            @(posedge hclk);
            n++;
        end
        while (i_sbc_if.take_vector !== 1'b1 && i_sbc_if.resume_next !== 1'b1) begin
            @(posedge hclk);
            m++;
        end
        e = SB << sel;
        if (xt != 0 && e < sbc_pkg::OFF_MIN_CYC) e = sbc_pkg::OFF_MIN_CYC;
        chk(n + 1 >= e && n <= e + 2, 1);
        e = xt != 0 ? (ack != 0 ? 10 : 4) : (ack != 0 ? 7 : 1);
        chk(m + 1 >= e && m <= e + 1, 1);
        chk(i_sbc_if.take_vector, ack);
        @(posedge hclk);
        chk(vector_taken, ack);
        chk(resumed, !ack);
        irq_flag <= 8'h00;
        irq_mask <= 8'hFF;
        repeat (3) @(posedge hclk);
        gates(0);
        bus(1'b0, sbc_pkg::OFS_STATUS, 32'h0);
        chk(rd[sbc_pkg::STAT_SETTLED], 1);
        chk(rd[sbc_pkg::STAT_SLEEP], 0);
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            report_and_stop;
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {hclk, hresetn, hsel, hwrite, int_ack_en, sleep_exec} = 6'h00;
        {adc_trigger, serial0_rx_trigger, intermediate_wakeup_state_done} = 3'h0;
        {haddr, hwdata, htrans, irq_flag} = 74'h0;
        irq_mask = 8'hFF;
        {err_total, cmp_count, cyc, sel, xt, ack, stb, en} = '0;
        void'($urandom(27598));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk(reset_fetch, 1);
        gates(0);
        bus(1'b0, sbc_pkg::OFS_CTRL, 32'h0);
        chk(rd, sbc_pkg::CTRL_RESET);
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        for (int k = 0; k < 8; k++) begin
            xt = k & 1;
            ack = (k >> 1) & 1;
            sel = $urandom_range(7);
            int_ack_en <= ack[0];
            w = (sel << 4) | (xt << 2) | $urandom_range(3);
            set_ctrl;
            sleep_go;
            gates(1);
            chk(cpu_halted, 1);
            bus(1'b0, sbc_pkg::OFS_STATUS, 32'h0);
            chk(rd[sbc_pkg::STAT_SLEEP], 1);
            irq_flag[3] <= 1'b1;
            repeat (20) @(posedge hclk);
            chk(i_sbc_if.cpu_clk_on, 0);
            wake($urandom_range(2));
        end
        w = 32'h00000070;
        set_ctrl;
        irq_flag[5] <= 1'b1;
        irq_mask[5] <= 1'b0;
        repeat (3) @(posedge hclk);
        sleep_exec <= 1'b1;
        @(posedge hclk);
        sleep_exec <= 1'b0;
        n = 0;
        while (i_sbc_if.take_vector !== 1'b1 && i_sbc_if.resume_next !== 1'b1) begin
            @(posedge hclk);
            n++;
            chk(i_sbc_if.cpu_clk_on, 1);
        end
        chk(n + 2 >= (SB << 7) && n <= (SB << 7) + 4, 1);
        irq_flag <= 8'h00;
        irq_mask <= 8'hFF;
        {xt, sel} = '0;
        w = 32'h0;
        set_ctrl;
        for (int t = 0; t < 2; t++) begin
            sleep_go;
            adc_trigger <= t[0];
            serial0_rx_trigger <= !t[0];
            for (n = 0; n < 50 && intermediate_wakeup_state_active !== 1'b1; n++) @(posedge hclk);
            chk(intermediate_wakeup_state_active, 1);
            chk(i_sbc_if.cpu_clk_on, 0);
            {adc_trigger, serial0_rx_trigger} <= 2'h0;
            intermediate_wakeup_state_done <= 1'b1;
            for (n = 0; n < 50 && intermediate_wakeup_state_active !== 1'b0; n++) @(posedge hclk);
            intermediate_wakeup_state_done <= 1'b0;
            chk(intermediate_wakeup_state_active, 0);
            chk(i_sbc_if.cpu_clk_on, 0);
            wake(1);
        end
        sleep_go;
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        {en, stb} = '0;
        chk(reset_fetch, 1);
        chk(cpu_halted, 0);
        gates(0);
        report_and_stop;
    end
endmodule
